// ==== hdl/durd_fifo.sv ====
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module durd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    // Fill level
    output logic [CW-1:0]         count_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_o != FULL);
    assign out_valid_o = (count_o != '0);
    assign out_data_o  = mem[rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wp      <= '0;
            rp      <= '0;
            count_o <= '0;
        end
        else if (flush_i)
        begin
            wp      <= '0;
            rp      <= '0;
            count_o <= '0;
        end
        else
        begin
            if (push)
                wp <= (wp == LAST) ? '0 : wp + 1'b1;
            if (pop)
                rp <= (rp == LAST) ? '0 : rp + 1'b1;
            if (push && !pop)
                count_o <= count_o + 1'b1;
            else if (pop && !push)
                count_o <= count_o - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wp] <= in_data_i;
    end
endmodule
`default_nettype wire

// ==== hdl/durd_pkg.sv ====
// Constants, types and decode helpers of the dual channel register decode
package durd_pkg;

    localparam int NCH    = 2;
    localparam int DATA_W = 8;

    // Register offsets within a channel set
    localparam logic [2:0] OFF_DATA    = 3'h0;
    localparam logic [2:0] OFF_INTEN   = 3'h1;
    localparam logic [2:0] OFF_FIFO    = 3'h2;
    localparam logic [2:0] OFF_LINE    = 3'h3;
    localparam logic [2:0] OFF_MODEM   = 3'h4;
    localparam logic [2:0] OFF_LSTAT   = 3'h5;
    localparam logic [2:0] OFF_MSTAT   = 3'h6;
    localparam logic [2:0] OFF_SCRATCH = 3'h7;

    // Field positions
    localparam int LCR_PAR_EN   = 3;
    localparam int LCR_PAR_EVEN = 4;
    localparam int LCR_DIV_BIT  = 7;
    localparam int MCR_RTS      = 1;
    localparam int MCR_LOOP     = 4;
    localparam int EXTRA_FEATURE_CONTROL_FILL    = 0;
    localparam int FCR_RX_RST   = 1;
    localparam int FCR_TX_RST   = 2;
    localparam int FCR_DMA      = 3;
    localparam int FC1_TX_DIS   = 1;

    // Key and set codes
    localparam logic [7:0] ENH_KEY    = 8'hbf;
    localparam logic [1:0] SET_FIRST  = 2'h1;
    localparam logic [1:0] SET_SECOND = 2'h2;

    // Reset and fixed read values
    localparam logic [7:0] REG_RST    = 8'h00;
    localparam logic [7:0] ISR_NONE   = 8'h01;
    localparam logic [7:0] MSR_IDLE   = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // Normal mode receive trigger levels and extended mode minimum
    localparam logic [7:0] RX_TRIG_0  = 8'h08;
    localparam logic [7:0] RX_TRIG_1  = 8'h10;
    localparam logic [7:0] RX_TRIG_2  = 8'h18;
    localparam logic [7:0] RX_TRIG_3  = 8'h1c;
    localparam logic [7:0] EXT_TRIG_MIN = 8'h01;

    // Serial timing, oversampling in baud ticks, frame length and parity index in bits
    localparam logic [3:0] OVS_LAST   = 4'hf;
    localparam logic [3:0] OVS_MID    = 4'h7;
    localparam logic [3:0] FRAME_PAR  = 4'hb;
    localparam logic [3:0] FRAME_NOPAR = 4'ha;
    localparam logic [3:0] IDX_PAR    = 4'h9;

    typedef struct packed {
        logic       a7;
        logic       chan;
        logic [2:0] off;
    } durd_acc_t;

    typedef enum logic [4:0] {
        SEL_NONE, SEL_RX_HOLD, SEL_TX_HOLD, SEL_DIV_LO, SEL_DIV_HI,
        SEL_INT_EN, SEL_INT_STAT, SEL_FIFO_CTRL, SEL_ENH_FEAT, SEL_TX_LVL,
        SEL_PRESCALE, SEL_LINE_CTRL, SEL_TX_FILL, SEL_MODEM_CTRL,
        SEL_RX_FILL, SEL_XON_FIRST, SEL_RX_LVL, SEL_TURN, SEL_LINE_STAT,
        SEL_EXTRA_CTRL, SEL_XON_SECOND, SEL_MODEM_STAT, SEL_XOFF_FIRST,
        SEL_FLOW_HI, SEL_FC2, SEL_SCRATCH, SEL_XOFF_SECOND, SEL_FLOW_LO,
        SEL_FC1
    } durd_reg_t;

    // Bank and offset to register, enhanced set first
    function automatic durd_reg_t durd_decode(input logic [2:0] off,
                                              input logic [7:0] line_control,
                                              input logic [7:0] extra_feature_control,
                                              input logic       wr);
        logic       enh;
        logic [1:0] set;
        durd_reg_t  r;
        enh = (line_control == ENH_KEY);
        set = extra_feature_control[2:1];
        r   = SEL_NONE;
        case (off)
            OFF_DATA:
                r = line_control[LCR_DIV_BIT] ? SEL_DIV_LO
                    : (wr ? SEL_TX_HOLD : SEL_RX_HOLD);
            OFF_INTEN:
                r = line_control[LCR_DIV_BIT] ? SEL_DIV_HI : SEL_INT_EN;
            OFF_FIFO:
                r = enh ? SEL_ENH_FEAT : (set == SET_FIRST) ? SEL_TX_LVL
                    : (set == SET_SECOND) ? SEL_PRESCALE
                    : (wr ? SEL_FIFO_CTRL : SEL_INT_STAT);
            OFF_LINE:
                r = (extra_feature_control[EXTRA_FEATURE_CONTROL_FILL] && !wr) ? SEL_TX_FILL
                    : (extra_feature_control[EXTRA_FEATURE_CONTROL_FILL] ? SEL_NONE : SEL_LINE_CTRL);
            OFF_MODEM:
                r = enh ? SEL_XON_FIRST : (set == SET_FIRST) ? SEL_RX_LVL
                    : (set == SET_SECOND) ? SEL_TURN
                    : extra_feature_control[EXTRA_FEATURE_CONTROL_FILL] ? (wr ? SEL_NONE : SEL_RX_FILL)
                    : SEL_MODEM_CTRL;
            OFF_LSTAT:
                r = enh ? SEL_XON_SECOND
                    : (wr ? SEL_EXTRA_CTRL : SEL_LINE_STAT);
            OFF_MSTAT:
                r = enh ? SEL_XOFF_FIRST : (set == SET_FIRST) ? SEL_FLOW_HI
                    : (set == SET_SECOND) ? SEL_FC2
                    : (wr ? SEL_NONE : SEL_MODEM_STAT);
            OFF_SCRATCH:
                r = enh ? SEL_XOFF_SECOND : (set == SET_FIRST) ? SEL_FLOW_LO
                    : (set == SET_SECOND) ? SEL_FC1 : SEL_SCRATCH;
            default:
                r = SEL_NONE;
        endcase
        return r;
    endfunction

    // Parity bit for a data byte
    function automatic logic durd_parity(input logic [7:0] d,
                                         input logic       even);
        return even ? ^d : ~^d;
    endfunction

endpackage

// ==== hdl/durd_top.sv ====
// Dual channel register decode with serial pins and FIFOs
//
// Summary of operation
// - Modem control bit 1 drives RTS low
// - Loopback feeds transmit stream into own receiver
// - TX pin idles high, also disabled or loopback
// - RX ready low on any data, or once data meets trigger with FIFO control bit3 set
// - TX ready low while a location is free
// - Select low, A7 low; A6 picks channel
// - Any nonzero level register means extended mode
// - Two channel register sets, offset A3..A1
// - General set decode with line control bit7 clear
// - Bit 7 set maps divisor low and high
// - Fill counts readable when extra control bit0 set
// - Key 0xBF maps enhanced feature and Xon/Xoff
// - Extra set 01b maps levels and flow counts
// - Extra set 10b maps prescale, timer, controls
// - Four normal or 128 extended trigger levels
// - 128-byte transmit and receive FIFO per channel
// - Start, stop, parity framing; parity errors flagged
// - Latch strobe low captures address byte
// - Read strobe fall drives register byte out
// - Write strobe rise stores bus byte
`timescale 1ns/1ps
`default_nettype none
module durd_top
    import durd_pkg::*;
#(
    parameter int FIFO_DEPTH = 128
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // Host multiplexed bus
    input  wire logic [7:0]       ad_i,
    output logic [7:0]            ad_o,
    output logic                  ad_oe_o,
    input  wire logic             cs_n_i,
    input  wire logic             address_latch_strobe_n_i,
    input  wire logic             read_strobe_n_i,
    input  wire logic             write_strobe_n_i,
    // Serial pins, index 0 is channel A
    input  wire logic [NCH-1:0]   rx_i,
    output logic [NCH-1:0]        tx_o,
    output logic [NCH-1:0]        rts_n_o,
    // DMA ready pins
    output logic [NCH-1:0]        rx_ready_out_n_o,
    output logic [NCH-1:0]        tx_ready_out_n_o
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    // Pin synchronisers
    logic [7:0]     ad_m;
    logic [7:0]     ad_s;
    logic [3:0]     ctl_m;
    logic [3:0]     ctl_s;
    logic [3:0]     ctl_d;
    logic [NCH-1:0] rx_m;
    logic [NCH-1:0] rx_s;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ad_m  <= 8'h00;
            ad_s  <= 8'h00;
            ctl_m <= 4'hf;
            ctl_s <= 4'hf;
            ctl_d <= 4'hf;
            rx_m  <= '1;
            rx_s  <= '1;
        end
        else
        begin
            ad_m  <= ad_i;
            ad_s  <= ad_m;
            ctl_m <= {cs_n_i, address_latch_strobe_n_i,
                      read_strobe_n_i, write_strobe_n_i};
            ctl_s <= ctl_m;
            ctl_d <= ctl_s;
            rx_m  <= rx_i;
            rx_s  <= rx_m;
        end
    end

    logic cs_n;
    logic als_n;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;

    assign cs_n    = ctl_s[3];
    assign als_n   = ctl_s[2];
    assign rd_fall = ctl_d[1] && !ctl_s[1];
    assign rd_rise = !ctl_d[1] && ctl_s[1];
    assign wr_rise = !ctl_d[0] && ctl_s[0];

    // Address phase
    durd_acc_t acc;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            acc <= '0;
        else if (!als_n)
            acc <= '{a7: ad_s[7], chan: ad_s[6], off: ad_s[3:1]};
    end

    // Channel steering
    logic hit;
    logic ch;

    assign hit = !cs_n && !acc.a7;
    assign ch  = acc.chan;

    // Per channel register storage
    logic [7:0] regs [NCH][32];
    logic [7:0] lsr [NCH];
    logic [7:0] rx_data [NCH];
    logic [CW-1:0] tx_cnt [NCH];
    logic [CW-1:0] rx_cnt [NCH];
    logic [NCH-1:0] tx_free;
    logic [NCH-1:0] tx_busy;
    logic [NCH-1:0] tx_flush;
    logic [NCH-1:0] rx_flush;
    logic [NCH-1:0] tx_push;
    logic [NCH-1:0] rx_pop;
    logic [NCH-1:0] lsr_clr;

    durd_reg_t rd_sel;
    durd_reg_t wr_sel;
    logic [7:0] rd_val;
    logic       wr_go;

    always_comb
    begin
        rd_sel = durd_decode(acc.off, regs[ch][SEL_LINE_CTRL],
                             regs[ch][SEL_EXTRA_CTRL], 1'b0);
        wr_sel = durd_decode(acc.off, regs[ch][SEL_LINE_CTRL],
                             regs[ch][SEL_EXTRA_CTRL], 1'b1);
    end

    // Read data mux
    always_comb
    begin
        case (rd_sel)
            SEL_RX_HOLD:    rd_val = rx_data[ch];
            SEL_INT_STAT:   rd_val = ISR_NONE;
            SEL_LINE_STAT:  rd_val = lsr[ch];
            SEL_MODEM_STAT: rd_val = MSR_IDLE;
            SEL_TX_FILL:    rd_val = 8'(tx_cnt[ch]);
            SEL_RX_FILL:    rd_val = 8'(rx_cnt[ch]);
            SEL_NONE:       rd_val = READ_ZERO;
            default:        rd_val = regs[ch][rd_sel];
        endcase
    end

    // Read cycle
    durd_reg_t rd_hold;
    logic      rd_ch;
    logic      rd_act;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ad_o    <= 8'h00;
            ad_oe_o <= 1'b0;
            rd_hold <= SEL_NONE;
            rd_ch   <= 1'b0;
            rd_act  <= 1'b0;
        end
        else if (rd_fall && hit)
        begin
            ad_o    <= rd_val;
            ad_oe_o <= 1'b1;
            rd_hold <= rd_sel;
            rd_ch   <= ch;
            rd_act  <= 1'b1;
        end
        else if (rd_rise || cs_n)
        begin
            ad_oe_o <= 1'b0;
            rd_act  <= 1'b0;
        end
    end

    assign wr_go = wr_rise && hit;

    // Side effects of accesses
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            tx_push[c]  = wr_go && (ch == c[0]) && (wr_sel == SEL_TX_HOLD);
            rx_pop[c]   = rd_rise && rd_act && (rd_ch == c[0])
                          && (rd_hold == SEL_RX_HOLD);
            lsr_clr[c]  = rd_rise && rd_act && (rd_ch == c[0])
                          && (rd_hold == SEL_LINE_STAT);
        end
    end

    // Register writes, all targets except SEL_NONE and SEL_TX_HOLD stored
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int c = 0; c < NCH; c++)
                for (int i = 0; i < 32; i++)
                    regs[c][i] <= REG_RST;
        end
        else if (wr_go && wr_sel != SEL_NONE && wr_sel != SEL_TX_HOLD)
            regs[ch][wr_sel] <= ad_s;
    end

    // Channel datapaths
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        logic [7:0]  line_control;
        logic [7:0]  fifo_control;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic        tick;
        logic        ext;
        logic        ext_d;
        logic        loop;
        logic        dis;
        logic [7:0]  trig;
        logic        rx_in;
        logic        tx_line;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        tx_pop;
        logic [3:0]  tx_os;
        logic [3:0]  tx_left;
        logic [10:0] tx_sh;
        logic        rx_busy;
        logic [3:0]  rx_os;
        logic [3:0]  rx_idx;
        logic [7:0]  rx_sh;
        logic        rx_par;
        logic        rx_push;
        logic        rx_ready;
        logic        ovr;
        logic        pe;
        logic        wr_fcr;

        assign line_control  = regs[g][SEL_LINE_CTRL];
        assign fifo_control  = regs[g][SEL_FIFO_CTRL];
        assign div  = {regs[g][SEL_DIV_HI], regs[g][SEL_DIV_LO]};
        assign loop = regs[g][SEL_MODEM_CTRL][MCR_LOOP];
        assign dis  = regs[g][SEL_FC1][FC1_TX_DIS];
        assign ext  = |{regs[g][SEL_TX_LVL], regs[g][SEL_RX_LVL],
                        regs[g][SEL_FLOW_HI], regs[g][SEL_FLOW_LO]};
        assign wr_fcr = wr_go && (ch == g[0]) && (wr_sel == SEL_FIFO_CTRL);
        assign tx_flush[g] = (wr_fcr && ad_s[FCR_TX_RST]) || (ext != ext_d);
        assign rx_flush[g] = (wr_fcr && ad_s[FCR_RX_RST]) || (ext != ext_d);
        assign rx_in   = loop ? tx_line : rx_s[g];
        assign tx_line = tx_busy[g] ? tx_sh[0] : 1'b1;
        assign tx_pop  = tick && !tx_busy[g] && tx_valid && !dis;

        // Trigger level selection
        always_comb
        begin
            if (ext)
                trig = (regs[g][SEL_RX_LVL] == 8'h00) ? EXT_TRIG_MIN
                       : regs[g][SEL_RX_LVL];
            else
                case (fifo_control[7:6])
                    2'h0:    trig = RX_TRIG_0;
                    2'h1:    trig = RX_TRIG_1;
                    2'h2:    trig = RX_TRIG_2;
                    default: trig = RX_TRIG_3;
                endcase
        end

        durd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CW)) u_txf (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .flush_i     (tx_flush[g]),
            .in_valid_i  (tx_push[g]),
            .in_ready_o  (tx_free[g]),
            .in_data_i   (ad_s),
            .out_valid_o (tx_valid),
            .out_ready_i (tx_pop),
            .out_data_o  (tx_data),
            .count_o     (tx_cnt[g])
        );

        durd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rxf (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .flush_i     (rx_flush[g]),
            .in_valid_i  (rx_push),
            .in_ready_o  (rx_ready),
            .in_data_i   (rx_sh),
            .out_valid_o (),
            .out_ready_i (rx_pop[g]),
            .out_data_o  (rx_data[g]),
            .count_o     (rx_cnt[g])
        );

        // Baud tick, sixteen per bit
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                bcnt  <= 16'h0000;
                tick  <= 1'b0;
                ext_d <= 1'b0;
            end
            else
            begin
                ext_d <= ext;
                if (div == 16'h0000 || bcnt >= div - 16'h0001)
                    bcnt <= 16'h0000;
                else
                    bcnt <= bcnt + 16'h0001;
                tick <= (div != 16'h0000) && (bcnt >= div - 16'h0001);
            end
        end

        // Transmitter
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                tx_busy[g] <= 1'b0;
                tx_os      <= 4'h0;
                tx_left    <= 4'h0;
                tx_sh      <= '1;
            end
            else if (tx_pop)
            begin
                tx_busy[g] <= 1'b1;
                tx_os      <= 4'h0;
                tx_left    <= line_control[LCR_PAR_EN] ? FRAME_PAR : FRAME_NOPAR;
                tx_sh      <= {1'b1, line_control[LCR_PAR_EN]
                               ? durd_parity(tx_data, line_control[LCR_PAR_EVEN])
                               : 1'b1, tx_data, 1'b0};
            end
            else if (tx_busy[g] && tick)
            begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == OVS_LAST)
                begin
                    tx_sh   <= {1'b1, tx_sh[10:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_left == 4'h1)
                        tx_busy[g] <= 1'b0;
                end
            end
        end

        // Receiver, sampling mid bit
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                rx_busy <= 1'b0;
                rx_os   <= 4'h0;
                rx_idx  <= 4'h0;
                rx_sh   <= 8'h00;
                rx_par  <= 1'b0;
                rx_push <= 1'b0;
            end
            else
            begin
                rx_push <= 1'b0;
                if (tick && !rx_busy && !rx_in)
                begin
                    rx_busy <= 1'b1;
                    rx_os   <= 4'h0;
                    rx_idx  <= 4'h0;
                end
                else if (tick && rx_busy)
                begin
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == OVS_MID)
                    begin
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == 4'h0 && rx_in)
                            rx_busy <= 1'b0;
                        else if (rx_idx >= 4'h1 && rx_idx <= 4'h8)
                            rx_sh <= {rx_in, rx_sh[7:1]};
                        else if (rx_idx == IDX_PAR && line_control[LCR_PAR_EN])
                            rx_par <= rx_in;
                        else if (rx_idx != 4'h0)
                        begin
                            rx_busy <= 1'b0;
                            rx_push <= 1'b1;
                        end
                    end
                end
            end
        end

        // Sticky line flags, a new event wins over the read clear
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                ovr <= 1'b0;
                pe  <= 1'b0;
            end
            else
            begin
                if (rx_push && !rx_ready)
                    ovr <= 1'b1;
                else if (lsr_clr[g])
                    ovr <= 1'b0;
                if (rx_push && line_control[LCR_PAR_EN] && rx_par
                    != durd_parity(rx_sh, line_control[LCR_PAR_EVEN]))
                    pe <= 1'b1;
                else if (lsr_clr[g])
                    pe <= 1'b0;
            end
        end

        assign lsr[g] = {1'b0, (tx_cnt[g] == '0) && !tx_busy[g],
                         tx_cnt[g] == '0, 2'b00, pe, ovr,
                         rx_cnt[g] != '0};

        // Registered pins
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                tx_o[g]             <= 1'b1;
                rts_n_o[g]          <= 1'b1;
                rx_ready_out_n_o[g] <= 1'b1;
                tx_ready_out_n_o[g] <= 1'b1;
            end
            else
            begin
                tx_o[g]    <= (loop || dis) ? 1'b1 : tx_line;
                rts_n_o[g] <= !regs[g][SEL_MODEM_CTRL][MCR_RTS];
                rx_ready_out_n_o[g] <= !((rx_cnt[g] != '0)
                    && (!fifo_control[FCR_DMA] || 8'(rx_cnt[g]) >= trig));
                tx_ready_out_n_o[g] <= !tx_free[g];
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/durd_checker.sv ====
// Pin checks of the register decode
`timescale 1ns/1ps
`default_nettype none
module durd_checker
    import durd_pkg::*;
#(parameter int FIFO_DEPTH = 128) (
    // Clock, reset and bus
    input wire logic           clk_i,
    input wire logic           nrst_i,
    input wire logic [7:0]     ad_i,
    input wire logic           ad_oe_o,
    input wire logic           cs_n_i,
    input wire logic           address_latch_strobe_n_i,
    input wire logic           read_strobe_n_i,
    input wire logic           write_strobe_n_i,
    // Serial pins
    input wire logic [NCH-1:0] tx_o,
    input wire logic [NCH-1:0] rts_n_o,
    input wire logic [NCH-1:0] rx_ready_out_n_o,
    input wire logic [NCH-1:0] tx_ready_out_n_o
);
    logic [1:0] adr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_i)
        if (!address_latch_strobe_n_i)
            adr <= ad_i[7:6];
    a_reset_pins: assert property ($rose(nrst_i) |-> tx_o == 2'h3
        && rts_n_o == 2'h3 && rx_ready_out_n_o == 2'h3) else $error("idle");
    a_txrdy_reset: assert property ($rose(nrst_i) |->
        ##[1:2] (tx_ready_out_n_o == 2'h0)) else $error("tx ready");
    a_read_drive: assert property ($fell(read_strobe_n_i) && !cs_n_i
        && !adr[1] |-> ##[2:6] ad_oe_o) else $error("no drive");
    a_drive_cause: assert property ($rose(ad_oe_o) |-> !adr[1]
        && !$past(cs_n_i, 3) && !$past(read_strobe_n_i, 3)) else $error("drive");
    a_drive_release: assert property ((cs_n_i || read_strobe_n_i) [*6]
        |-> !ad_oe_o) else $error("bus held");
    a_rts_write: assert property (!$stable(rts_n_o)
        |-> !$past(write_strobe_n_i, 7)) else $error("rts cause");
    a_rts_chan_a: assert property (!$stable(rts_n_o[0]) |-> !adr[0])
        else $error("rts a");
    a_rts_chan_b: assert property (!$stable(rts_n_o[1]) |-> adr[0])
        else $error("rts b");
endmodule
bind durd_top durd_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .ad_i(ad_i), .ad_oe_o(ad_oe_o),
    .cs_n_i(cs_n_i), .address_latch_strobe_n_i(address_latch_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .tx_o(tx_o), .rts_n_o(rts_n_o), .rx_ready_out_n_o(rx_ready_out_n_o),
    .tx_ready_out_n_o(tx_ready_out_n_o));
`default_nettype wire

// ==== tb/durd_host_model.sv ====
// Host model on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module durd_host_model (
    // Clock and bus
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,
    // Drive
    output logic [7:0]      ad_o,
    output logic            cs_n_o,
    output logic            als_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o
);
    initial {ad_o, cs_n_o, als_n_o, rd_n_o, wr_n_o} = 12'h00f;
    task automatic acc(input logic w, input logic [7:0] a,
                       inout logic [7:0] d);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        ad_o = a;
        als_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        als_n_o = 1'b1;
        ad_o = w ? d : ~a;
        repeat (4) @(negedge clk_i);
        wr_n_o = !w;
        rd_n_o = w;
        repeat (8) @(negedge clk_i);
        @(posedge clk_i);
        d = w ? d : bus_i;
        @(negedge clk_i);
        {rd_n_o, wr_n_o} = 2'h3;
        repeat (8) @(negedge clk_i);
        cs_n_o = 1'b1;
        ad_o = ~ad_o;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_dual_uart_register_decode.sv ====
// Bench of the dual channel register decode
`timescale 1ns/1ps
`default_nettype none
module test_dual_uart_register_decode;
    import durd_pkg::*;
    logic           clk_i = 1'b0;
    logic           nrst_i = 1'b0;
    logic [7:0]     bus, had, ad_o;
    logic           ad_oe_o, cs_n, als_n, rd_n, wr_n;
    logic [NCH-1:0] rx_i = 2'h3;
    logic [NCH-1:0] tx_o, rts_n_o, rx_ready_out_n_o, tx_ready_out_n_o;
    int             n_errors = 0;
    int             num_checks = 0;
    assign bus = ad_oe_o ? ad_o : had;
    initial forever #2 clk_i = ~clk_i;
    durd_top #(.FIFO_DEPTH(8)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .ad_i(bus), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .cs_n_i(cs_n),
        .address_latch_strobe_n_i(als_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .rx_i(rx_i), .tx_o(tx_o), .rts_n_o(rts_n_o),
        .rx_ready_out_n_o(rx_ready_out_n_o),
        .tx_ready_out_n_o(tx_ready_out_n_o));
    durd_host_model host (.clk_i(clk_i), .bus_i(bus), .ad_o(had),
        .cs_n_o(cs_n), .als_n_o(als_n), .rd_n_o(rd_n), .wr_n_o(wr_n));
    function automatic logic [7:0] ra(input int c, input int o);
        return {1'b0, c[0], 2'h0, o[2:0], 1'b0};
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.acc(1'b0, a, d);
        chk(d, e);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({tx_o, rts_n_o, rx_ready_out_n_o, tx_ready_out_n_o}, 8'hfc);
        wr(ra(0, 7), 8'h5a);
        wr(ra(1, 7), 8'ha5);
        wr(ra(0, 7) | 8'h80, 8'h11);
        wr(ra(0, 6), 8'h33);
        rd(ra(0, 7), 8'h5a);
        rd(ra(1, 7), 8'ha5);
        rd(ra(0, 6), MSR_IDLE);
        wr(ra(0, 3), 8'h80);
        wr(ra(0, 0), 8'h12);
        wr(ra(0, 1), 8'h34);
        rd(ra(0, 0), 8'h12);
        rd(ra(0, 1), 8'h34);
        wr(ra(0, 3), ENH_KEY);
        for (int o = 2; o < 8; o++)
            if (o != 3) wr(ra(0, o), {5'h18, o[2:0]});
        for (int o = 2; o < 8; o++)
            rd(ra(0, o), o == 3 ? ENH_KEY : {5'h18, o[2:0]});
        wr(ra(0, 3), 8'h00);
        rd(ra(0, 2), ISR_NONE);
        rd(ra(0, 7), 8'h5a);
        rd(ra(0, 1), REG_RST);
        wr(ra(0, 5), 8'h02);
        wr(ra(0, 2), 8'h10);
        wr(ra(0, 5), 8'h04);
        wr(ra(0, 2), 8'h33);
        rd(ra(0, 2), 8'h33);
        wr(ra(0, 5), 8'h02);
        rd(ra(0, 2), 8'h10);
        wr(ra(0, 2), 8'h00);
        wr(ra(0, 5), 8'h00);
        wr(ra(0, 4), 8'h02);
        chk({6'h0, rts_n_o}, 8'h02);
        wr(ra(1, 4), 8'h02);
        wr(ra(0, 4), 8'h00);
        chk({6'h0, rts_n_o}, 8'h01);
        wr(ra(1, 2), 8'h08);
        for (int i = 0; i < 9; i++)
            wr(ra(1, 0), i[7:0]);
        chk({4'h0, tx_o, tx_ready_out_n_o}, 8'h0e);
        wr(ra(1, 5), 8'h01);
        rd(ra(1, 3), 8'h08);
        wr(ra(1, 3), 8'h55);
        wr(ra(1, 5), 8'h00);
        rd(ra(1, 3), 8'h00);
        wr(ra(1, 2), 8'h0c);
        chk({6'h0, tx_ready_out_n_o}, 8'h00);
        wr(ra(1, 3), 8'h80);
        wr(ra(1, 0), 8'h01);
        wr(ra(1, 3), 8'h00);
        wr(ra(1, 4), 8'h10);
        wr(ra(1, 0), 8'hc3);
        repeat (200) @(negedge clk_i);
        chk({4'h0, tx_o, rx_ready_out_n_o}, 8'h0f);
        wr(ra(1, 2), 8'h00);
        chk({6'h0, rx_ready_out_n_o}, 8'h01);
        rd(ra(1, 0), 8'hc3);
        give_verdict;
    end
    initial
    begin
        #100us;
        n_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
